// ===== rbc_cell.sv
// package of bit attributes plus the single-bit access cell
`timescale 1ns/1ps
`default_nettype none

package rbc_pkg;

    // access attribute carried by one bit cell
    typedef enum logic [3:0] {
        RBC_RO,       // read only, follows hardware level
        RBC_RDSET,    // read_sets_bit
        RBC_RC,       // read to clear
        RBC_WO,       // write only
        RBC_WC,       // write one to clear
        RBC_ANYCLR,   // write_any_clear
        RBC_LATLO,    // latch_low_bit
        RBC_LATHI,    // latch_high_bit
        RBC_SELFCLR,  // self_clearing
        RBC_SS,       // self setting
        RBC_STICKY,   // sticky_phy_status
        RBC_RW,       // plain read/write
        RBC_RSVD      // reserved, constant zero
    } rbc_attr_e;

    // bank width and bit placement
    localparam int REG_WIDTH = 16;
    localparam int BIT_RO      = 0;
    localparam int BIT_RDSET   = 1;
    localparam int BIT_RC      = 2;
    localparam int BIT_WO      = 3;
    localparam int BIT_WC      = 4;
    localparam int BIT_ANYCLR  = 5;
    localparam int BIT_LATLO   = 6;
    localparam int BIT_LATHI   = 7;
    localparam int BIT_SELFCLR = 8;
    localparam int BIT_SS      = 9;
    localparam int BIT_STICKY  = 10;
    localparam int BIT_LITE    = 11;   // lite_reset_immune read/write bit
    localparam int BIT_SOFT    = 12;   // soft_reset_immune read/write bit
    localparam int BIT_PLAIN   = 13;   // ordinary read/write bit

    // attribute of every bit position, index 0 first
    localparam rbc_attr_e BIT_ATTR [REG_WIDTH] = '{
        RBC_RO, RBC_RDSET, RBC_RC, RBC_WO, RBC_WC, RBC_ANYCLR, RBC_LATLO, RBC_LATHI,
        RBC_SELFCLR, RBC_SS, RBC_STICKY, RBC_RW, RBC_RW, RBC_RW, RBC_RSVD, RBC_RSVD
    };

    // value after any reset; latch-low and self-setting rest at one
    localparam logic [REG_WIDTH-1:0] RST_VALUE   = 16'h0240;
    // bits that keep their state across a lite reset
    localparam logic [REG_WIDTH-1:0] LITE_IMMUNE = 16'h0800;
    // bits that keep their state across a software reset
    localparam logic [REG_WIDTH-1:0] SOFT_IMMUNE = 16'h1000;
    // bits whose value shows on a read; write-only and reserved read zero
    localparam logic [REG_WIDTH-1:0] READ_MASK   = 16'h3ff7;

endpackage

// one bit of storage with its access attribute
module rbc_cell #(
    parameter rbc_pkg::rbc_attr_e ATTR        = rbc_pkg::RBC_RW,
    parameter logic               RST_VAL     = 1'b0,
    parameter logic               LITE_IMMUNE = 1'b0,
    parameter logic               SOFT_IMMUNE = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic rdStb,     // read access of the register
    input  wire logic wrStb,     // write access of the register
    input  wire logic wrBit,     // data written to this position
    input  wire logic hwEv,      // hardware event pulse
    input  wire logic hwLevel,   // hardware condition level
    input  wire logic liteRst,   // synchronous lite reset
    input  wire logic softRst,   // synchronous software reset
    output logic      value      // stored bit
);

    logic value_r;    // the bit itself
    logic value_nxt;
    logic rel_r;      // sticky bit already read, now free to fall
    logic rel_nxt;

    assign value = value_r;

    // -------------------------------------------------------------
    // next value by attribute
    // -------------------------------------------------------------
    // hardware sets beat software clears in the same cycle; a software
    // start beats the completion event of a self-clearing/setting bit
    always_comb
    begin
        value_nxt = value_r;
        rel_nxt   = 1'b0;
        case (ATTR)
            rbc_pkg::RBC_RO:      value_nxt = hwLevel;
            rbc_pkg::RBC_RDSET:   value_nxt = rdStb | (wrStb ? wrBit : value_r);
            rbc_pkg::RBC_RC:      value_nxt = hwEv | (value_r & ~rdStb);
            rbc_pkg::RBC_WO:      value_nxt = wrStb ? wrBit : value_r;
            rbc_pkg::RBC_RW:      value_nxt = wrStb ? wrBit : value_r;
            rbc_pkg::RBC_WC:      value_nxt = hwEv | (value_r & ~(wrStb & wrBit));
            rbc_pkg::RBC_ANYCLR:  value_nxt = hwEv | (value_r & ~wrStb);
            rbc_pkg::RBC_LATLO:   value_nxt = hwLevel & (value_r | rdStb);
            rbc_pkg::RBC_LATHI:   value_nxt = hwLevel | (value_r & ~rdStb);
            rbc_pkg::RBC_SELFCLR: value_nxt = (wrStb & wrBit) | (value_r & ~hwEv);
            rbc_pkg::RBC_SS:      value_nxt = ~(wrStb & ~wrBit) & (value_r | hwEv);
            rbc_pkg::RBC_STICKY:
            begin
                // held until read; after the read it follows the cause down
                value_nxt = hwLevel | (value_r & ~(rel_r | rdStb));
                rel_nxt   = value_nxt & (rel_r | rdStb);
            end
            rbc_pkg::RBC_RSVD:   value_nxt = 1'b0;
            default:             value_nxt = value_r;
        endcase
        // functional resets, each skipped by bits immune to it
        if ((liteRst && !LITE_IMMUNE) || (softRst && !SOFT_IMMUNE))
        begin
            value_nxt = RST_VAL;
            rel_nxt   = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            value_r <= RST_VAL;
            rel_r   <= 1'b0;
        end
        else
        begin
            value_r <= value_nxt;
            rel_r   <= rel_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== rbc_register_bank.sv
// register bank built from access cells, every attribute used at least once
// -----------------------------------------------------------------
// Summary of operation
// - read-only bits ignore writes, read current value
// - read-to-set bit becomes one on read
// - read-to-clear returns value, then clears; writes ignored
// - write-only accepts writes; reads as zero
// - write one clears bit; zero keeps it
// - any write clears write-any-clear field
// - latch low/high hold until register read
// - self-clearing returns to zero; zero writes ignored
// - self-setting returns to one; one writes ignored
// - sticky status high until read, then follows cause
// - lite-reset-immune bits survive lite reset
// - soft-reset-immune bits survive software reset
// -----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module rbc_register_bank (
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    input  wire logic                          rdStb,    // one-cycle read access
    input  wire logic                          wrStb,    // one-cycle write access
    input  wire logic [rbc_pkg::REG_WIDTH-1:0] wrData,   // write data
    input  wire logic [rbc_pkg::REG_WIDTH-1:0] hwEv,     // hardware event pulses
    input  wire logic [rbc_pkg::REG_WIDTH-1:0] hwLevel,  // hardware condition levels
    input  wire logic                          liteRst,  // lite reset pulse
    input  wire logic                          softRst,  // software reset pulse
    output logic      [rbc_pkg::REG_WIDTH-1:0] rdData,   // read data, one cycle after rdStb
    output logic      [rbc_pkg::REG_WIDTH-1:0] regValue  // stored bits, to the device logic
);

    localparam int W = rbc_pkg::REG_WIDTH;

    logic [W-1:0] cellVal;     // cell outputs, each a flip-flop
    logic [W-1:0] rdData_r;    // captured read word
    logic [W-1:0] rdData_nxt;

    assign regValue = cellVal;
    assign rdData   = rdData_r;

    // -------------------------------------------------------------
    // bit cells
    // -------------------------------------------------------------
    // one cell per position; attribute and reset behaviour from the map
    generate
        for (genvar i = 0; i < W; i++)
        begin : g_bit
            rbc_cell #(
                .ATTR        (rbc_pkg::BIT_ATTR[i]),
                .RST_VAL     (rbc_pkg::RST_VALUE[i]),
                .LITE_IMMUNE (rbc_pkg::LITE_IMMUNE[i]),
                .SOFT_IMMUNE (rbc_pkg::SOFT_IMMUNE[i])
            ) u_cell (
                .core_clk (core_clk),
                .nrst     (nrst),
                .rdStb    (rdStb),
                .wrStb    (wrStb),
                .wrBit    (wrData[i]),
                .hwEv     (hwEv[i]),
                .hwLevel  (hwLevel[i]),
                .liteRst  (liteRst),
                .softRst  (softRst),
                .value    (cellVal[i])
            );
        end
    endgenerate

    // -------------------------------------------------------------
    // read data capture
    // -------------------------------------------------------------
    // the word is taken before the read side effects land, so a
    // read-to-clear bit still shows its old value to software
    always_comb
    begin
        rdData_nxt = rdData_r;
        if (rdStb)
        begin
            // write-only and reserved positions read as zero
            rdData_nxt = cellVal & rbc_pkg::READ_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdData_r <= '0;
        end
        else
        begin
            rdData_r <= rdData_nxt;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    // shorthand: no functional reset this cycle
    logic quiet;
    assign quiet = !liteRst && !softRst;

    // read-only bit follows its level whatever is written
    property p_ro_follows;
        @(posedge core_clk) disable iff (!nrst)
        (wrStb && quiet) |=> (cellVal[rbc_pkg::BIT_RO] == $past(hwLevel[rbc_pkg::BIT_RO]));
    endproperty
    a_ro_follows: assert property (p_ro_follows)
        else $error("read-only bit did not follow its level");

    // read sets the bit, even if zero is written alongside
    property p_rdset;
        @(posedge core_clk) disable iff (!nrst)
        (rdStb && quiet) |=> cellVal[rbc_pkg::BIT_RDSET];
    endproperty
    a_rdset: assert property (p_rdset)
        else $error("read-to-set bit not set by read");

    // read returns the old value, then the bit is gone
    property p_rc_clear;
        @(posedge core_clk) disable iff (!nrst)
        (rdStb && cellVal[rbc_pkg::BIT_RC] && !hwEv[rbc_pkg::BIT_RC] && quiet)
            |=> (rdData[rbc_pkg::BIT_RC] && !cellVal[rbc_pkg::BIT_RC]);
    endproperty
    a_rc_clear: assert property (p_rc_clear)
        else $error("read-to-clear bit not returned then cleared");

    // writes never clear a read-to-clear bit
    property p_rc_nowrite;
        @(posedge core_clk) disable iff (!nrst)
        (wrStb && !rdStb && cellVal[rbc_pkg::BIT_RC] && quiet) |=> cellVal[rbc_pkg::BIT_RC];
    endproperty
    a_rc_nowrite: assert property (p_rc_nowrite)
        else $error("write disturbed read-to-clear bit");

    // write-only bit stores data yet reads as zero
    property p_wo_store;
        @(posedge core_clk) disable iff (!nrst)
        (wrStb && quiet) ##1 (rdStb && !wrStb && quiet)
            |=> (!rdData[rbc_pkg::BIT_WO]
                 && cellVal[rbc_pkg::BIT_WO] == $past(wrData[rbc_pkg::BIT_WO], 2));
    endproperty
    a_wo_store: assert property (p_wo_store)
        else $error("write-only bit not stored or leaked on read");

    // one clears, zero keeps
    property p_wc;
        @(posedge core_clk) disable iff (!nrst)
        (wrStb && !hwEv[rbc_pkg::BIT_WC] && quiet)
            |=> (cellVal[rbc_pkg::BIT_WC]
                 == ($past(cellVal[rbc_pkg::BIT_WC]) && !$past(wrData[rbc_pkg::BIT_WC])));
    endproperty
    a_wc: assert property (p_wc)
        else $error("write-one-to-clear bit misbehaved");

    // event in the clearing cycle survives
    property p_wc_set_wins;
        @(posedge core_clk) disable iff (!nrst)
        (hwEv[rbc_pkg::BIT_WC] && quiet) |=> cellVal[rbc_pkg::BIT_WC];
    endproperty
    a_wc_set_wins: assert property (p_wc_set_wins)
        else $error("event lost against clear");

    // any write clears, whatever the data
    property p_anyclr;
        @(posedge core_clk) disable iff (!nrst)
        (wrStb && !hwEv[rbc_pkg::BIT_ANYCLR] && quiet) |=> !cellVal[rbc_pkg::BIT_ANYCLR];
    endproperty
    a_anyclr: assert property (p_anyclr)
        else $error("write-anything-to-clear bit not cleared");

    // latched high holds for two unread cycles though the cause left
    sequence s_lathi_unread;
        (cellVal[rbc_pkg::BIT_LATHI] && !rdStb && quiet) ##1 (!rdStb && quiet);
    endsequence
    property p_lathi_hold;
        @(posedge core_clk) disable iff (!nrst)
        s_lathi_unread |=> cellVal[rbc_pkg::BIT_LATHI];
    endproperty
    a_lathi_hold: assert property (p_lathi_hold)
        else $error("latch-high bit released without read");

    // latched low stays low until read
    property p_latlo_hold;
        @(posedge core_clk) disable iff (!nrst)
        (!cellVal[rbc_pkg::BIT_LATLO] && !rdStb && quiet) |=> !cellVal[rbc_pkg::BIT_LATLO];
    endproperty
    a_latlo_hold: assert property (p_latlo_hold)
        else $error("latch-low bit released without read");

    // written one holds until the completion event, then drops
    sequence s_selfclr_start;
        wrStb && wrData[rbc_pkg::BIT_SELFCLR] && quiet;
    endsequence
    sequence s_selfclr_done;
        hwEv[rbc_pkg::BIT_SELFCLR] && !wrStb && quiet;
    endsequence
    property p_selfclr;
        @(posedge core_clk) disable iff (!nrst)
        s_selfclr_start ##1 s_selfclr_done
            |-> cellVal[rbc_pkg::BIT_SELFCLR] ##1 !cellVal[rbc_pkg::BIT_SELFCLR];
    endproperty
    a_selfclr: assert property (p_selfclr)
        else $error("self-clearing bit did not clear after event");

    // writing zero leaves a self-clearing bit alone
    property p_selfclr_zero;
        @(posedge core_clk) disable iff (!nrst)
        (wrStb && !wrData[rbc_pkg::BIT_SELFCLR] && !hwEv[rbc_pkg::BIT_SELFCLR] && quiet)
            |=> $stable(cellVal[rbc_pkg::BIT_SELFCLR]);
    endproperty
    a_selfclr_zero: assert property (p_selfclr_zero)
        else $error("zero write changed self-clearing bit");

    // written zero holds until the completion event, then returns to one
    sequence s_ss_start;
        wrStb && !wrData[rbc_pkg::BIT_SS] && quiet;
    endsequence
    sequence s_ss_done;
        hwEv[rbc_pkg::BIT_SS] && !wrStb && quiet;
    endsequence
    property p_ss;
        @(posedge core_clk) disable iff (!nrst)
        s_ss_start ##1 s_ss_done |-> !cellVal[rbc_pkg::BIT_SS] ##1 cellVal[rbc_pkg::BIT_SS];
    endproperty
    a_ss: assert property (p_ss)
        else $error("self-setting bit did not recover");

    // sticky status: unread stays high; read and cause gone falls
    // once read, the bit may follow its cause down, so the hold check
    // only applies while the cell has not yet seen a read
    logic stickyFree;   // sticky bit already read
    assign stickyFree = g_bit[rbc_pkg::BIT_STICKY].u_cell.rel_r;
    property p_sticky_hold;
        @(posedge core_clk) disable iff (!nrst)
        (cellVal[rbc_pkg::BIT_STICKY] && !stickyFree && !rdStb && quiet) ##1 (!rdStb && quiet)
            |=> cellVal[rbc_pkg::BIT_STICKY];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky status fell before read");

    property p_sticky_fall;
        @(posedge core_clk) disable iff (!nrst)
        (rdStb && quiet) ##1 (!hwLevel[rbc_pkg::BIT_STICKY] && quiet)
            |=> !cellVal[rbc_pkg::BIT_STICKY];
    endproperty
    a_sticky_fall: assert property (p_sticky_fall)
        else $error("sticky status stuck after read and cause gone");

    // immune bits ride through their reset; plain bit does not
    property p_lite;
        @(posedge core_clk) disable iff (!nrst)
        (liteRst && !softRst && !wrStb)
            |=> ($stable(cellVal[rbc_pkg::BIT_LITE]) && !cellVal[rbc_pkg::BIT_PLAIN]);
    endproperty
    a_lite: assert property (p_lite)
        else $error("lite reset handling wrong");

    property p_soft;
        @(posedge core_clk) disable iff (!nrst)
        (softRst && !liteRst && !wrStb)
            |=> ($stable(cellVal[rbc_pkg::BIT_SOFT]) && !cellVal[rbc_pkg::BIT_PLAIN]);
    endproperty
    a_soft: assert property (p_soft)
        else $error("software reset handling wrong");

    // reserved positions never show a one
    property p_rsvd;
        @(posedge core_clk) disable iff (!nrst)
        rdStb |=> (rdData[15:14] == 2'h0 && cellVal[15:14] == 2'h0);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit read nonzero");

endmodule

`default_nettype wire

// ===== rbc_register_bank_tb.sv
// self-checking testbench for the register bank of access cells
`timescale 1ns/1ps
`default_nettype none

module rbc_register_bank_tb;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        core_clk;      // 10 MHz bench clock
    logic        nrst;          // async reset, active low
    logic        rdStb;         // read access pulse
    logic        wrStb;         // write access pulse
    logic [15:0] wrData;        // write word
    logic [15:0] hwEv;          // hardware event pulses
    logic [15:0] hwLevel;       // hardware condition levels
    logic        liteRst;       // lite reset pulse
    logic        softRst;       // software reset pulse
    logic [15:0] rdData;        // read word from the bank
    logic [15:0] regValue;      // stored bits of the bank
    int          n_mismatch;    // mismatches seen
    int          total_checks;  // comparisons made
    int          cycleCount;    // watchdog count

    rbc_register_bank dut (
        .core_clk (core_clk),
        .nrst     (nrst),
        .rdStb    (rdStb),
        .wrStb    (wrStb),
        .wrData   (wrData),
        .hwEv     (hwEv),
        .hwLevel  (hwLevel),
        .liteRst  (liteRst),
        .softRst  (softRst),
        .rdData   (rdData),
        .regValue (regValue)
    );

    // ---------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ---------------------------------------------------------------
    // free-running clock, 100 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // the whole run needs under 200 cycles; 2000 means a hang
    always @(posedge core_clk)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 2000)
        begin
            n_mismatch = n_mismatch + 1;
            finish_test();
        end
    end

    // one comparison, reported at once on a mismatch
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one cycle of access: driven at a falling edge, judged at the next;
    // each signal is assigned once per time step, so no clearing here
    task automatic step(input logic rd, input logic wr, input logic [15:0] d,
                        input logic [15:0] ev);
        rdStb  = rd;
        wrStb  = wr;
        wrData = d;
        hwEv   = ev;
        @(negedge core_clk);
    endtask

    // verdict and end of run, the only exit
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // values held in reset, reserved bits zero
    task automatic t_reset();
        chk("reset value", regValue, 16'h0240);
        chk("reset rdData", rdData, 16'h0000);
    endtask

    // read-only bit follows its level and ignores writes
    task automatic t_ro();
        hwLevel[0] = 1'b1;
        step(1'b0, 1'b1, 16'h0000, 16'h0000);
        chk("ro after zero write", regValue & 16'h0001, 16'h0001);
        hwLevel[0] = 1'b0;
        step(1'b1, 1'b1, 16'h0001, 16'h0000);
        chk("ro after one write", regValue & 16'h0001, 16'h0000);
    endtask

    // read sets, even with a zero written in the same cycle
    task automatic t_rdset();
        step(1'b0, 1'b1, 16'h0000, 16'h0000);
        chk("read-set before read", regValue & 16'h0002, 16'h0000);
        step(1'b1, 1'b1, 16'h0000, 16'h0000);
        chk("read-set after read", regValue & 16'h0002, 16'h0002);
    endtask

    // read returns the bit then clears it; writes change nothing
    task automatic t_rc();
        step(1'b0, 1'b0, 16'h0000, 16'h0004);
        step(1'b0, 1'b1, 16'h0000, 16'h0000);
        chk("rc after write", regValue & 16'h0004, 16'h0004);
        step(1'b1, 1'b0, 16'h0000, 16'h0000);
        chk("rc read value", rdData & 16'h0004, 16'h0004);
        chk("rc cleared", regValue & 16'h0004, 16'h0000);
    endtask

    // write-only bit takes the write; its read value is not judged
    task automatic t_wo();
        step(1'b0, 1'b1, 16'h0008, 16'h0000);
        chk("wo stored", regValue & 16'h0008, 16'h0008);
        step(1'b1, 1'b0, 16'h0000, 16'h0000);
        chk("wo kept over read", regValue & 16'h0008, 16'h0008);
    endtask

    // write one clears, zero keeps; any write clears the other field
    task automatic t_wc_anyclr();
        step(1'b0, 1'b0, 16'h0000, 16'h0030);
        step(1'b0, 1'b1, 16'h0020, 16'h0000);
        chk("wc zero write", regValue & 16'h0010, 16'h0010);
        chk("any-write clear", regValue & 16'h0020, 16'h0000);
        step(1'b0, 1'b1, 16'h0010, 16'h0000);
        chk("wc one write", regValue & 16'h0010, 16'h0000);
    endtask

    // latch-low and latch-high hold until the register is read
    task automatic t_latch();
        hwLevel[7:6] = 2'b10;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        hwLevel[7:6] = 2'b01;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        chk("latches held", regValue & 16'h00c0, 16'h0080);
        step(1'b1, 1'b0, 16'h0000, 16'h0000);
        chk("latches read", rdData & 16'h00c0, 16'h0080);
        chk("latches released", regValue & 16'h00c0, 16'h0040);
    endtask

    // self-clearing set by a one, ignores zero, clears on completion
    task automatic t_selfclr();
        step(1'b0, 1'b1, 16'h0100, 16'h0000);
        step(1'b0, 1'b1, 16'h0000, 16'h0000);
        chk("self-clear zero write", regValue & 16'h0100, 16'h0100);
        // start again so the completion event follows a start directly
        step(1'b0, 1'b1, 16'h0100, 16'h0000);
        step(1'b1, 1'b0, 16'h0000, 16'h0100);
        chk("self-clear read", rdData & 16'h0100, 16'h0100);
        chk("self-clear done", regValue & 16'h0100, 16'h0000);
    endtask

    // self-setting cleared by a zero, ignores one, sets on completion
    task automatic t_ss();
        step(1'b0, 1'b1, 16'h0000, 16'h0000);
        step(1'b0, 1'b1, 16'h0200, 16'h0000);
        chk("ss one write", regValue & 16'h0200, 16'h0000);
        // clear again so the completion event follows a clear directly
        step(1'b0, 1'b1, 16'h0000, 16'h0000);
        step(1'b1, 1'b0, 16'h0000, 16'h0200);
        chk("ss read", rdData & 16'h0200, 16'h0000);
        chk("ss self set", regValue & 16'h0200, 16'h0200);
    endtask

    // sticky status: held without a read, then follows its cause
    task automatic t_sticky();
        hwLevel[10] = 1'b1;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        hwLevel[10] = 1'b0;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        chk("sticky unread", regValue & 16'h0400, 16'h0400);
        hwLevel[10] = 1'b1;
        step(1'b1, 1'b0, 16'h0000, 16'h0000);
        chk("sticky read", rdData & 16'h0400, 16'h0400);
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        chk("sticky cause on", regValue & 16'h0400, 16'h0400);
        hwLevel[10] = 1'b0;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        chk("sticky cause gone", regValue & 16'h0400, 16'h0000);
    endtask

    // immune bits survive their reset, the others return to reset value
    task automatic t_immune();
        step(1'b0, 1'b1, 16'h3800, 16'h0000);
        liteRst = 1'b1;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        liteRst = 1'b0;
        chk("lite reset", regValue & 16'h3800, 16'h0800);
        step(1'b0, 1'b1, 16'h3800, 16'h0000);
        softRst = 1'b1;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        softRst = 1'b0;
        chk("soft reset", regValue & 16'h3800, 16'h1000);
    endtask

    // reserved positions are written with zeros and read back zero
    task automatic t_rsvd();
        step(1'b0, 1'b1, 16'h3000, 16'h0000);
        chk("rsvd stored", regValue & 16'hc000, 16'h0000);
        step(1'b1, 1'b0, 16'h0000, 16'h0000);
        chk("rsvd read", rdData & 16'hf000, 16'h3000);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        nrst         = 1'b0;
        rdStb        = 1'b0;
        wrStb        = 1'b0;
        wrData       = 16'h0000;
        hwEv         = 16'h0000;
        hwLevel      = 16'h0040;
        liteRst      = 1'b0;
        softRst      = 1'b0;
        n_mismatch   = 0;
        total_checks = 0;
        cycleCount   = 0;
        repeat (12) @(negedge core_clk);
        t_reset();
        nrst = 1'b1;
        step(1'b0, 1'b0, 16'h0000, 16'h0000);
        t_ro();
        t_rdset();
        t_rc();
        t_wo();
        t_wc_anyclr();
        t_latch();
        t_selfclr();
        t_ss();
        t_sticky();
        t_immune();
        t_rsvd();
        finish_test();
    end

endmodule

`default_nettype wire
